// >>> pkg/bps_map.vh
// Purpose: Constants for the buck protection supervisor
// Assumes: 250 MHz supervisor clock, Wishbone byte addresses
// Notes: How it works list below
// How it works
// - Pre-biased start keeps both switches off
// - Power good held low before soft start ends
// - Power good released after thirty microsecond qualification
// - Leaving window with hysteresis drops power good
// - Power good window and hysteresis are settings
// - Fault output low on any fault, else released
// - Peak limit cuts high side, enables low side
// - High side blocked until below valley limit
// - Peak and valley limits set separately
// - First peak event starts selectable cycle timer
// - Limit every cycle over timer enters short handling
// - Under-voltage while limiting means dead short
// - Short handling: hiccup, continue, or latch-off
// - Hiccup disables stage, restarts soft start, repeats
// - Hiccup off time from soft start and duty
// - Output over-voltage: disabled, discharge or latch-off
// - Input over-voltage stops switching, resumes when cleared
// - Thermal trip shuts down, restarts soft start after hysteresis
// - Thermal threshold and hysteresis are settings
// - Low bootstrap voltage forces high side off
// - Soft start 1ms default, 0.5, 2, 4ms
`ifndef BPS_MAP_VH
`define BPS_MAP_VH
// Clock and timing
`define BPS_CLK_MHZ 250
`define BPS_FSW_KHZ 600
`define BPS_SS_T0_US 500
`define BPS_SS_T1_US 1000
`define BPS_SS_T2_US 2000
`define BPS_SS_T3_US 4000
`define BPS_PG_DLY_US 30
// Register byte offsets
`define BPS_REG_LIMITS 8'h00
`define BPS_REG_THERM 8'h04
`define BPS_REG_CTRL 8'h08
`define BPS_REG_STATUS 8'h0C
// Reset values
`define BPS_LIMITS_RST 32'h3040020A
`define BPS_THERM_RST 32'h327819AF
`define BPS_CTRL_RST 32'h00000C01
// Control field positions
`define BPS_SS_SEL 1:0
`define BPS_OCP_SEL 3:2
`define BPS_SCP_MODE 5:4
`define BPS_OVP_MODE 7:6
`define BPS_VOVP_EN 8
`define BPS_VOVP_SEL 9
`define BPS_HIC_DUTY 13:10
// Mode encodings
`define BPS_SCP_HICCUP 2'h0
`define BPS_SCP_CONT 2'h1
`define BPS_SCP_LATCH 2'h2
`define BPS_OVP_DISCH 2'h1
`define BPS_OVP_LATCH 2'h2
`endif

// >>> rtl/bps_supervisor.v
// Purpose: Protection and status supervisor for one buck phase
// Assumes: Comparator flags from the analog stage, Wishbone slave
// Notes: Threshold settings drive analog DAC ports
`include "bps_map.vh"
`default_nettype none
module bps_supervisor #(
   parameter SS_CYC_0 = `BPS_SS_T0_US * `BPS_CLK_MHZ,
   parameter SS_CYC_1 = `BPS_SS_T1_US * `BPS_CLK_MHZ,
   parameter SS_CYC_2 = `BPS_SS_T2_US * `BPS_CLK_MHZ,
   parameter SS_CYC_3 = `BPS_SS_T3_US * `BPS_CLK_MHZ,
   parameter PG_DLY_CYC = `BPS_PG_DLY_US * `BPS_CLK_MHZ,
   parameter SW_PERIOD_CYC = `BPS_CLK_MHZ * 1000 / `BPS_FSW_KHZ
) (
   input wire clk,
   input wire rstn,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire enable_pin,
   input wire vin_present,
   input wire fb_above_ramp,
   input wire pwm_on_req,
   input wire peak_over,
   input wire valley_below,
   input wire out_in_window,
   input wire out_under,
   input wire out_over,
   input wire vin_over,
   input wire temp_over,
   input wire temp_cool,
   input wire boot_low,
   output reg high_side_switch,
   output reg low_side_switch,
   output reg ramp_reset,
   output reg discharge_en,
   output wire output_good_flag_o,
   output reg output_good_flag_oe,
   output wire fault_indicator_n_o,
   output reg fault_indicator_n_oe,
   output wire [7:0] cfg_pg_window,
   output wire [7:0] cfg_pg_hyst,
   output wire [7:0] cfg_peak_limit,
   output wire [7:0] cfg_valley_limit,
   output wire [7:0] cfg_therm_limit,
   output wire [7:0] cfg_therm_hyst,
   output wire [7:0] cfg_ovp_limit,
   output wire [7:0] cfg_uv_limit,
   output wire cfg_vin_ovp_sel
);
   localparam ST_OFF = 3'h0;
   localparam ST_SS = 3'h1;
   localparam ST_RUN = 3'h2;
   localparam ST_HIC = 3'h3;
   localparam ST_LATCH = 3'h4;
   localparam ST_THERM = 3'h5;

   function [31:0] bps_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer i;
      begin
         bps_merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               bps_merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   function [25:0] bps_ss_len;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: bps_ss_len = SS_CYC_0[25:0];
            2'h1: bps_ss_len = SS_CYC_1[25:0];
            2'h2: bps_ss_len = SS_CYC_2[25:0];
            default: bps_ss_len = SS_CYC_3[25:0];
         endcase
      end
   endfunction

   reg [31:0] reg_limits;
   reg [31:0] reg_therm;
   reg [31:0] reg_ctrl;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [25:0] st_cnt;
   reg [15:0] pg_cnt;
   reg pg_ok;
   reg started;
   reg oc_block;
   reg oc_run;
   reg oc_hit;
   reg [8:0] oc_cnt;
   reg scp_flag;
   reg [15:0] per_cnt;
   reg tick;
   wire [12:0] fl;
   wire en_s;
   wire vin_s;
   wire fb_s;
   wire pwm_s;
   wire peak_s;
   wire valley_s;
   wire win_s;
   wire under_s;
   wire over_s;
   wire vovp_s;
   wire thot_s;
   wire tcool_s;
   wire boot_s;
   wire [25:0] ss_len;
   wire [25:0] hic_len;
   wire [8:0] oc_len;
   wire [8:0] oc_inc;
   wire active;
   wire prebias;
   wire vin_stop;
   wire ovp_disch;
   wire ovp_latch;
   wire run_ok;
   wire peak_ev;
   wire scp_now;
   wire next_hs;
   wire wr;
   wire [31:0] status;
   reg [31:0] rdata;

   bps_sync #(
      .W(13)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .d({enable_pin, vin_present, fb_above_ramp, pwm_on_req, peak_over, valley_below,
          out_in_window, out_under, out_over, vin_over, temp_over, temp_cool, boot_low}),
      .q(fl)
   );

   assign {en_s, vin_s, fb_s, pwm_s, peak_s, valley_s, win_s, under_s, over_s, vovp_s, thot_s,
           tcool_s, boot_s} = fl;

   // Settings to the analog comparators
   assign cfg_pg_window = reg_limits[7:0];
   assign cfg_pg_hyst = reg_limits[15:8];
   assign cfg_peak_limit = reg_limits[23:16];
   assign cfg_valley_limit = reg_limits[31:24];
   assign cfg_therm_limit = reg_therm[7:0];
   assign cfg_therm_hyst = reg_therm[15:8];
   assign cfg_ovp_limit = reg_therm[23:16];
   assign cfg_uv_limit = reg_therm[31:24];
   assign cfg_vin_ovp_sel = reg_ctrl[`BPS_VOVP_SEL];
   assign output_good_flag_o = 1'b0;
   assign fault_indicator_n_o = 1'b0;

   // Timing lengths
   assign ss_len = bps_ss_len(reg_ctrl[`BPS_SS_SEL]);
   assign hic_len = ss_len * {22'h0, reg_ctrl[`BPS_HIC_DUTY]} + ss_len;
   assign oc_len = 9'h020 << reg_ctrl[`BPS_OCP_SEL];
   assign oc_inc = oc_cnt + 9'h001;

   // Protection conditions
   assign active = (state == ST_SS) || (state == ST_RUN);
   assign prebias = (state == ST_SS) && !started && fb_s;
   assign vin_stop = reg_ctrl[`BPS_VOVP_EN] && vovp_s;
   assign ovp_disch = (reg_ctrl[`BPS_OVP_MODE] == `BPS_OVP_DISCH) && over_s;
   assign ovp_latch = (reg_ctrl[`BPS_OVP_MODE] == `BPS_OVP_LATCH) && over_s;
   assign run_ok = active && !prebias && !vin_stop && !ovp_disch;
   assign peak_ev = peak_s && high_side_switch;
   assign scp_now = (tick && oc_run && (oc_hit || peak_ev) && (oc_inc >= oc_len))
                    || (oc_run && under_s);
   assign next_hs = run_ok && pwm_s && !oc_block && !peak_s && !boot_s;

   // Switching period divider
   always @(posedge clk) begin
      if (!rstn) begin
         per_cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (per_cnt >= SW_PERIOD_CYC[15:0] - 16'h0001) begin
         per_cnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         per_cnt <= per_cnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   // Sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (en_s && vin_s) begin
               next_state = ST_SS;
            end
         end
         ST_SS, ST_RUN, ST_HIC: begin
            if (thot_s) begin
               next_state = ST_THERM;
            end else if (ovp_latch) begin
               next_state = ST_LATCH;
            end else if (scp_now && reg_ctrl[`BPS_SCP_MODE] == `BPS_SCP_LATCH) begin
               next_state = ST_LATCH;
            end else if (scp_now && reg_ctrl[`BPS_SCP_MODE] != `BPS_SCP_CONT) begin
               next_state = ST_HIC;
            end else if (state == ST_SS && st_cnt >= ss_len) begin
               next_state = ST_RUN;
            end else if (state == ST_HIC && st_cnt >= hic_len) begin
               next_state = ST_SS;
            end
         end
         ST_THERM: begin
            if (tcool_s && !thot_s) begin
               next_state = ST_SS;
            end
         end
         ST_LATCH: begin
            next_state = ST_LATCH;
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
      if (!en_s || !vin_s) begin
         next_state = ST_OFF;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         state <= ST_OFF;
         st_cnt <= 26'h0000000;
         started <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            st_cnt <= 26'h0000000;
         end else if (st_cnt != 26'h3FFFFFF) begin
            st_cnt <= st_cnt + 26'h0000001;
         end
         if (next_state != state) begin
            started <= 1'b0;
         end else if (state == ST_SS && !fb_s) begin
            started <= 1'b1;
         end
      end
   end

   // Current limit and overcurrent timer
   always @(posedge clk) begin
      if (!rstn) begin
         oc_block <= 1'b0;
         oc_run <= 1'b0;
         oc_hit <= 1'b0;
         oc_cnt <= 9'h000;
         scp_flag <= 1'b0;
      end else begin
         if (peak_s) begin
            oc_block <= 1'b1;
         end else if (valley_s || !active) begin
            oc_block <= 1'b0;
         end
         if (scp_now || !active) begin
            oc_run <= 1'b0;
            oc_hit <= 1'b0;
            oc_cnt <= 9'h000;
         end else if (!oc_run) begin
            if (peak_ev) begin
               oc_run <= 1'b1;
               oc_hit <= 1'b1;
               oc_cnt <= 9'h000;
            end
         end else if (tick) begin
            if (oc_hit || peak_ev) begin
               oc_cnt <= oc_inc;
            end else begin
               oc_run <= 1'b0;
            end
            oc_hit <= 1'b0;
         end else if (peak_ev) begin
            oc_hit <= 1'b1;
         end
         if (scp_now) begin
            scp_flag <= 1'b1;
         end else if ((state == ST_RUN && !oc_run && !under_s) || state == ST_OFF) begin
            scp_flag <= 1'b0;
         end
      end
   end

   // Power good qualification
   always @(posedge clk) begin
      if (!rstn) begin
         pg_cnt <= 16'h0000;
         pg_ok <= 1'b0;
      end else if (state != ST_RUN || !win_s) begin
         pg_cnt <= 16'h0000;
         pg_ok <= 1'b0;
      end else if (pg_cnt >= PG_DLY_CYC[15:0]) begin
         pg_ok <= 1'b1;
      end else begin
         pg_cnt <= pg_cnt + 16'h0001;
      end
   end

   // Drive outputs
   always @(posedge clk) begin
      if (!rstn) begin
         high_side_switch <= 1'b0;
         low_side_switch <= 1'b0;
         ramp_reset <= 1'b1;
         discharge_en <= 1'b0;
         output_good_flag_oe <= 1'b0;
         fault_indicator_n_oe <= 1'b0;
      end else begin
         high_side_switch <= next_hs;
         low_side_switch <= run_ok && !next_hs;
         ramp_reset <= !active;
         discharge_en <= ovp_disch;
         output_good_flag_oe <= vin_s && !pg_ok;
         fault_indicator_n_oe <= vin_stop || over_s || scp_flag || state == ST_THERM
                                 || state == ST_LATCH;
      end
   end

   // Wishbone slave
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign status = {20'h00000, !fault_indicator_n_oe, pg_ok, started, state == ST_THERM,
                    vin_stop, over_s, scp_flag, oc_run, oc_block, state};

   always @* begin
      case (wb_adr_i)
         `BPS_REG_LIMITS: rdata = reg_limits;
         `BPS_REG_THERM: rdata = reg_therm;
         `BPS_REG_CTRL: rdata = {18'h00000, reg_ctrl[13:0]};
         `BPS_REG_STATUS: rdata = status;
         default: rdata = 32'h00000000;
      endcase
   end

   always @(posedge clk) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         reg_limits <= `BPS_LIMITS_RST;
         reg_therm <= `BPS_THERM_RST;
         reg_ctrl <= `BPS_CTRL_RST;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= rdata;
         end
         if (wr && wb_adr_i == `BPS_REG_LIMITS) begin
            reg_limits <= bps_merge(reg_limits, wb_dat_i, wb_sel_i);
         end
         if (wr && wb_adr_i == `BPS_REG_THERM) begin
            reg_therm <= bps_merge(reg_therm, wb_dat_i, wb_sel_i);
         end
         if (wr && wb_adr_i == `BPS_REG_CTRL) begin
            reg_ctrl <= bps_merge(reg_ctrl, wb_dat_i, wb_sel_i) & 32'h00003FFF;
         end
      end
   end
endmodule // bps_supervisor
`default_nettype wire

// >>> rtl/bps_sync.v
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes: Output changes once stages two and three agree
`default_nettype none
module bps_sync #(
   parameter W = 1
) (
   input wire clk,
   input wire rstn,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] s1;
   reg [W-1:0] s2;
   reg [W-1:0] s3;
   wire [W-1:0] agree;

   assign agree = ~(s2 ^ s3);

   always @(posedge clk) begin
      if (!rstn) begin
         s1 <= {W{1'b0}};
         s2 <= {W{1'b0}};
         s3 <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q <= (s3 & agree) | (q & ~agree);
      end
   end
endmodule // bps_sync
`default_nettype wire

// >>> sim/bps_stage_model.sv
// Purpose: Behavioural inductor current and modulator
// Assumes: Limits follow the supervisor threshold outputs
// Notes: short_i makes the current climb fast
`default_nettype none
module bps_stage_model (
   input wire logic clk,
   input wire logic high_side_switch,
   input wire logic short_i,
   input wire logic [7:0] cfg_peak_limit,
   input wire logic [7:0] cfg_valley_limit,
   output logic peak_over = 1'h0,
   output logic valley_below = 1'h1,
   output logic pwm_on_req = 1'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   int cur = 0;
   int ph = 0;
   // Rises while high side conducts, else decays
   always @(posedge clk) begin
      ph <= (ph + 1) % 16;
      pwm_on_req <= ph < 10;
      if (high_side_switch) begin
         cur <= (cur > 200) ? 255 : cur + (short_i ? 16 : 2);
      end else begin
         cur <= (cur > 4) ? cur - 4 : 0;
      end
      peak_over <= cur > cfg_peak_limit;
      valley_below <= cur < cfg_valley_limit;
   end
endmodule // bps_stage_model
`default_nettype wire

// >>> sim/bps_supervisor_properties.sv
// Purpose: Timing checks on the supervisor outputs
// Assumes: Flags reach the outputs within six clocks
// Notes: Bound from the testbench top file
`default_nettype none
module bps_supervisor_properties #(
   parameter int PG_DLY_CYC = 50
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic vin_present,
   input wire logic fb_above_ramp,
   input wire logic peak_over,
   input wire logic valley_below,
   input wire logic out_in_window,
   input wire logic out_over,
   input wire logic boot_low,
   input wire logic high_side_switch,
   input wire logic low_side_switch,
   input wire logic ramp_reset,
   input wire logic output_good_flag_oe,
   input wire logic fault_indicator_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] win_cnt;
   logic [3:0] vin_cnt;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Saturating run lengths of window and input present
   always @(posedge clk) begin
      win_cnt <= (!rstn || !out_in_window) ? 16'h0000 : win_cnt + {15'h0000, win_cnt != 16'hFFFF};
      vin_cnt <= (!rstn || !vin_present) ? 4'h0 : vin_cnt + {3'h0, vin_cnt != 4'hF};
   end
   a_ramp_blocks_stage: assert property (
      ramp_reset && $past(ramp_reset) |-> !high_side_switch && !low_side_switch)
      else $error("Switch on while ramp held");
   a_prebias_hold: assert property (
      (fb_above_ramp && ramp_reset)[*5] ##1 (fb_above_ramp && !ramp_reset)[*7]
      |-> !high_side_switch && !low_side_switch)
      else $error("Switch on over pre-biased output");
   a_pg_low_start: assert property (
      (vin_present && ramp_reset)[*7] |-> output_good_flag_oe)
      else $error("Power good released before soft start");
   a_pg_qualified: assert property (
      $fell(output_good_flag_oe) && vin_cnt == 4'hF |-> win_cnt >= PG_DLY_CYC)
      else $error("Power good released too early");
   a_pg_window_loss: assert property (
      (!out_in_window && vin_present)[*7] |-> output_good_flag_oe)
      else $error("Power good high outside window");
   a_fault_on_ovp: assert property (
      out_over[*7] |-> fault_indicator_n_oe)
      else $error("Fault pin released during over-voltage");
   a_peak_cuts_hs: assert property (
      peak_over[*7] |-> !high_side_switch)
      else $error("High side on above peak limit");
   a_valley_gate: assert property (
      (peak_over && !valley_below)[*7] ##1 (!valley_below)[*7] |-> !high_side_switch)
      else $error("High side on before valley reached");
   a_boot_refresh: assert property (
      boot_low[*7] |-> !high_side_switch)
      else $error("High side on with low bootstrap");
endmodule // bps_supervisor_properties
`default_nettype wire

// >>> sim/test_bps_supervisor.sv
// Purpose: Self-checking bench for the buck protection supervisor
// Assumes: Shortened soft start, delay and period parameters
// Notes: Register rows first, then protection scenarios
`include "bps_map.vh"
`default_nettype none
module test_bps_supervisor;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat; logic [31:0] exp;} bps_row_t;
   logic clk = 1'h0, rstn = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic enable_pin = 1'h0, vin_present = 1'h1, fb_above_ramp = 1'h1, out_in_window = 1'h0, out_under = 1'h0;
   logic out_over = 1'h0, vin_over = 1'h0, temp_over = 1'h0, temp_cool = 1'h1, boot_low = 1'h0, short_i = 1'h0;
   logic wb_ack_o, peak_over, valley_below, pwm_on_req, high_side_switch, low_side_switch, ramp_reset, h;
   logic discharge_en, output_good_flag_oe, fault_indicator_n_oe, cfg_vin_ovp_sel;
   logic output_good_flag_o, fault_indicator_n_o;
   logic [7:0] cfg_ovp_limit, cfg_uv_limit;
   logic [7:0] cfg_pg_window, cfg_pg_hyst, cfg_peak_limit, cfg_valley_limit, cfg_therm_limit, cfg_therm_hyst;
   int n_mismatch = 0, checks_done = 0;
   bps_row_t rows [10] = '{'{1'h0, `BPS_REG_LIMITS, 4'hF, 32'h0, `BPS_LIMITS_RST},
      '{1'h0, `BPS_REG_THERM, 4'hF, 32'h0, `BPS_THERM_RST}, '{1'h0, `BPS_REG_CTRL, 4'hF, 32'h0, `BPS_CTRL_RST},
      '{1'h1, 8'h10, 4'hF, 32'hFFFFFFFF, 32'h0}, '{1'h0, 8'h10, 4'hF, 32'h0, 32'h0},
      '{1'h1, `BPS_REG_LIMITS, 4'h1, 32'h11223344, 32'h0}, '{1'h0, `BPS_REG_LIMITS, 4'hF, 32'h0, 32'h30400244},
      '{1'h1, `BPS_REG_CTRL, 4'hF, 32'hFFFFFFFF, 32'h0}, '{1'h0, `BPS_REG_CTRL, 4'hF, 32'h0, 32'h00003FFF},
      '{1'h1, `BPS_REG_CTRL, 4'hF, `BPS_CTRL_RST, 32'h0}};
   bps_supervisor #(.SS_CYC_0(200), .SS_CYC_1(400), .SS_CYC_2(800), .SS_CYC_3(1600), .PG_DLY_CYC(50),
      .SW_PERIOD_CYC(16)) u_dut (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .enable_pin, .vin_present, .fb_above_ramp, .pwm_on_req, .peak_over, .valley_below,
      .out_in_window, .out_under, .out_over, .vin_over, .temp_over, .temp_cool, .boot_low, .high_side_switch,
      .low_side_switch, .ramp_reset, .discharge_en, .output_good_flag_o, .output_good_flag_oe,
      .fault_indicator_n_o, .fault_indicator_n_oe, .cfg_pg_window, .cfg_pg_hyst, .cfg_peak_limit,
      .cfg_valley_limit, .cfg_therm_limit, .cfg_therm_hyst, .cfg_ovp_limit, .cfg_uv_limit, .cfg_vin_ovp_sel);
   bps_stage_model u_stage (.clk, .high_side_switch, .short_i, .cfg_peak_limit, .cfg_valley_limit, .peak_over,
      .valley_below, .pwm_on_req);
   always #2 clk = ~clk;
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic watch(input int n, output logic seen);
      seen = 1'h0;
      repeat (n) begin
         tk(1);
         seen = seen | high_side_switch;
      end
   endtask
   task automatic wt(input bit on_ramp, input logic v, input int n);
      int k;
      k = 0;
      while ((on_ramp ? ramp_reset : high_side_switch) !== v && k < n) begin
         tk(1);
         k++;
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, s, d};
      do begin
         tk(1);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      if (wb_ack_o !== 1'h1) n_mismatch++;
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      tk(1);
   endtask
   task automatic results;
      $display("Mismatches %0d of %0d checks", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      tk(40000);
      n_mismatch++;
      results();
   end
   initial begin
      tk(10);
      chk({high_side_switch, low_side_switch, ramp_reset, output_good_flag_oe, fault_indicator_n_oe}, 5'h04);
      rstn <= 1'h1;
      tk(20);
      foreach (rows[k]) begin
         wb(rows[k].we, rows[k].adr, rows[k].sel, rows[k].dat, rd);
         if (!rows[k].we) chk(rd, rows[k].exp);
      end
      chk({cfg_pg_hyst, cfg_pg_window}, 16'h0244);
      chk({cfg_valley_limit, cfg_peak_limit}, 16'h3040);
      chk({cfg_therm_hyst, cfg_therm_limit}, 16'h19AF);
      chk({cfg_uv_limit, cfg_ovp_limit}, 16'h3278);
      chk({output_good_flag_o, fault_indicator_n_o}, 2'h0);
      // Pre-biased start, then power good
      enable_pin <= 1'h1;
      watch(100, h);
      chk({h, low_side_switch}, 2'h0);
      chk(output_good_flag_oe, 1'h1);
      fb_above_ramp <= 1'h0;
      wt(0, 1'h1, 600);
      chk(high_side_switch, 1'h1);
      tk(500);
      out_in_window <= 1'h1;
      tk(40);
      chk(output_good_flag_oe, 1'h1);
      tk(30);
      chk(output_good_flag_oe, 1'h0);
      out_in_window <= 1'h0;
      tk(8);
      chk(output_good_flag_oe, 1'h1);
      // Output and input over-voltage
      chk(fault_indicator_n_oe, 1'h0);
      out_over <= 1'h1;
      tk(8);
      chk({fault_indicator_n_oe, discharge_en}, 2'h2);
      wb(1'h1, `BPS_REG_CTRL, 4'hF, 32'h00000C41, rd);
      tk(8);
      chk(discharge_en, 1'h1);
      out_over <= 1'h0;
      tk(8);
      chk({fault_indicator_n_oe, discharge_en}, 2'h0);
      wb(1'h1, `BPS_REG_CTRL, 4'hF, 32'h00000F01, rd);
      chk(cfg_vin_ovp_sel, 1'h1);
      vin_over <= 1'h1;
      tk(8);
      watch(40, h);
      chk({h, fault_indicator_n_oe}, 2'h1);
      vin_over <= 1'h0;
      wt(0, 1'h1, 2000);
      chk(high_side_switch, 1'h1);
      // Bootstrap refresh and thermal trip
      boot_low <= 1'h1;
      tk(8);
      watch(40, h);
      chk(h, 1'h0);
      boot_low <= 1'h0;
      {temp_over, temp_cool} <= 2'h2;
      tk(8);
      chk({ramp_reset, fault_indicator_n_oe}, 2'h3);
      temp_over <= 1'h0;
      tk(50);
      chk(ramp_reset, 1'h1);
      temp_cool <= 1'h1;
      tk(8);
      chk(ramp_reset, 1'h0);
      // Dead short in hiccup, continue and latch modes
      tk(500);
      {short_i, out_under} <= 2'h3;
      wt(1, 1'h1, 300);
      chk(ramp_reset, 1'h1);
      {short_i, out_under} <= 2'h0;
      tk(1500);
      chk(ramp_reset, 1'h1);
      tk(200);
      chk(ramp_reset, 1'h0);
      tk(500);
      wb(1'h1, `BPS_REG_CTRL, 4'hF, 32'h00000C11, rd);
      {short_i, out_under} <= 2'h3;
      tk(300);
      chk({ramp_reset, fault_indicator_n_oe}, 2'h1);
      {short_i, out_under} <= 2'h0;
      wb(1'h1, `BPS_REG_CTRL, 4'hF, 32'h00000C21, rd);
      tk(300);
      {short_i, out_under} <= 2'h3;
      wt(1, 1'h1, 300);
      {short_i, out_under} <= 2'h0;
      tk(2500);
      chk(ramp_reset, 1'h1);
      enable_pin <= 1'h0;
      tk(10);
      enable_pin <= 1'h1;
      wt(1, 1'h0, 100);
      chk(ramp_reset, 1'h0);
      // Output over-voltage latch, left by removing input
      wb(1'h1, `BPS_REG_CTRL, 4'hF, 32'h00000C81, rd);
      out_over <= 1'h1;
      tk(8);
      out_over <= 1'h0;
      tk(8);
      chk({ramp_reset, fault_indicator_n_oe}, 2'h3);
      vin_present <= 1'h0;
      tk(8);
      chk({ramp_reset, output_good_flag_oe}, 2'h2);
      vin_present <= 1'h1;
      wt(1, 1'h0, 100);
      chk(ramp_reset, 1'h0);
      // Reset in mid-run
      rstn <= 1'h0;
      tk(10);
      chk({high_side_switch, low_side_switch, ramp_reset, output_good_flag_oe, fault_indicator_n_oe}, 5'h04);
      rstn <= 1'h1;
      tk(1);
      wb(1'h0, `BPS_REG_CTRL, 4'hF, 32'h0, rd);
      chk(rd, `BPS_CTRL_RST);
      results();
   end
endmodule // test_bps_supervisor
bind bps_supervisor bps_supervisor_properties #(.PG_DLY_CYC(PG_DLY_CYC)) u_props (.clk, .rstn, .vin_present,
   .fb_above_ramp, .peak_over, .valley_below, .out_in_window, .out_over, .boot_low, .high_side_switch,
   .low_side_switch, .ramp_reset, .output_good_flag_oe, .fault_indicator_n_oe);
`default_nettype wire
